// file: common/jct_pkg.sv
// Package for the jump and condition transfer unit
package jct_pkg;

    localparam int          WORD_W       = 24;
    localparam int          ADDR_W       = 15;
    localparam int          FLAG_W       = 6;
    localparam int          PIT_W        = 12;
    localparam int          PIT_AW       = 7;
    localparam logic [5:0]  OPC_KEY      = 6'h00;
    localparam logic [5:0]  OPC_UNCOND   = 6'h01;
    localparam logic [5:0]  OPC_INDEX    = 6'h02;
    localparam logic [5:0]  OPC_COMPARE  = 6'h03;
    localparam logic [5:0]  OPC_DECIMAL  = 6'h38;
    localparam logic [5:0]  OPC_SPECIAL  = 6'h3f;
    localparam logic [5:0]  SUB_PIT_WR   = 6'h34;
    localparam logic [5:0]  SUB_PIT_RD   = 6'h35;
    localparam logic [5:0]  SUB_CHAN_RD  = 6'h2d;
    localparam logic [5:0]  SUB_FLAGS    = 6'h33;
    localparam logic [5:0]  SUB_ORIGIN   = 6'h2e;
    localparam logic [2:0]  FLAGS_SAVE_X = 3'h0;
    localparam logic [2:0]  FLAGS_REST_X = 3'h4;
    localparam logic [2:0]  KEY_RETURN   = 3'h7;
    localparam int          PIT_MOD_BIT  = 11;
    localparam int          FLAG_BOUND   = 0;
    localparam int          FLAG_PSTATE  = 5;
    localparam logic [5:0]  FLAGS_RESET  = 6'h00;
    localparam logic [14:0] IDX_ZERO     = 15'h0000;
    localparam logic [14:0] IDX_NEGZERO  = 15'h7fff;

    typedef enum logic [1:0] {
        JCT_SAME_VALUE,
        JCT_DIFFERS,
        JCT_AT_LEAST,
        JCT_BELOW
    } jct_cmp_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] word;
        logic [14:0] p;
        logic [14:0] eff_addr;
        logic [23:0] acc;
        logic [23:0] aux;
        logic [14:0] idx1;
        logic [14:0] idx2;
        logic [14:0] idx3;
    } jct_req_t;

    typedef struct packed {
        logic        done;
        logic        branch;
        logic [14:0] next_p;
        logic        acc_we;
        logic [23:0] acc;
        logic        idx_we;
        logic [1:0]  idx_sel;
        logic [14:0] idx;
        logic        mem_we;
        logic        mem_monitor;
        logic [14:0] mem_addr;
        logic [14:0] mem_data;
        logic        trap;
    } jct_resp_t;

endpackage : jct_pkg

// file: src/jct_compare.sv
// Algebraic one's-complement comparison for the compare branches
`timescale 1ns/10ps
`default_nettype none
module jct_compare
    import jct_pkg::*;
#(
    parameter int W = 24
)
(
    // Operands
    input  wire logic [W-1:0]       lhs,
    input  wire logic [W-1:0]       rhs,
    input  wire jct_pkg::jct_cmp_t  sel,
    // Result
    output logic                    hit
);
    logic           eq_val;
    logic           lhs_zero;
    logic           rhs_zero;
    logic           lt_val;
    logic [W:0]     lk;
    logic [W:0]     rk;

    always_comb
    begin
        lhs_zero = (lhs == '0) || (lhs == '1);
        rhs_zero = (rhs == '0) || (rhs == '1);
        eq_val   = (lhs == rhs) || (lhs_zero && rhs_zero);
        // Ordering key: sign bit inverted, negative values kept unflipped, so minus zero sits below plus zero
        lk       = lhs[W-1] ? {1'b0, ~lhs} ^ {1'b0, {W{1'b1}}} : {1'b1, lhs};
        rk       = rhs[W-1] ? {1'b0, ~rhs} ^ {1'b0, {W{1'b1}}} : {1'b1, rhs};
        lt_val   = lk < rk;
        unique case (sel)
            JCT_SAME_VALUE: hit = eq_val;
            JCT_DIFFERS:    hit = !eq_val;
            JCT_AT_LEAST:   hit = !lt_val;
            JCT_BELOW:      hit = lt_val;
        endcase
    end
endmodule : jct_compare
`default_nettype wire

// file: src/jct_unit.sv
// Jump and condition transfer unit
`timescale 1ns/10ps
`default_nettype none
module jct_unit
    import jct_pkg::*;
#(
    parameter int PIT_DEPTH = 128
)
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // Instruction request
    input  wire jct_pkg::jct_req_t   req,
    // Surroundings
    input  wire logic [2:0]          channel_index_value,
    input  wire logic [5:0]          jump_keys,
    input  wire logic                multiprog_present,
    input  wire logic                decimal_present,
    input  wire logic                decimal_switch_on,
    input  wire logic [1:0]          decimal_unit_result_flags,
    input  wire logic                int_recognised,
    // Results
    output jct_pkg::jct_resp_t       resp,
    output logic [5:0]               condition_flags,
    output logic [14:0]              last_branch_origin,
    output logic                     int_hold
);

    jct_resp_t      resp_reg;
    jct_resp_t      resp_next;
    logic [5:0]     flags_reg;
    logic [5:0]     flags_next;
    logic [14:0]    origin_reg;
    logic [14:0]    origin_next;
    logic           hold_save_reg;
    logic           hold_save_next;
    logic           hold_exit_reg;
    logic           hold_exit_next;
    logic           int_hold_reg;
    logic           pit_we;
    logic [6:0]     pit_addr;
    logic [11:0]    pit_wdata;
    logic [11:0]    page_index_table [PIT_DEPTH];
    logic           cmp_hit;
    logic [23:0]    cmp_rhs;

    // Field decoding
    logic [5:0]     opc;
    logic [2:0]     fj;
    logic [1:0]     fb;
    logic           fsel;
    logic [14:0]    fm;
    logic [5:0]     sub;
    logic [2:0]     subx;
    logic [14:0]    p_inc;
    logic [14:0]    idx_cur;
    logic           is_jump;

    function automatic logic [14:0] oc_inc(input logic [14:0] v);
        logic [15:0] s;
        s = {1'b0, v} + 16'h0001;
        s = {1'b0, s[14:0]} + {15'h0000, s[15]};
        oc_inc = (s[14:0] == IDX_NEGZERO) ? IDX_ZERO : s[14:0];
    endfunction : oc_inc

    function automatic logic [14:0] oc_dec(input logic [14:0] v);
        logic [15:0] s;
        s = {1'b0, v} + 16'h7ffe;
        s = {1'b0, s[14:0]} + {15'h0000, s[15]};
        oc_dec = (s[14:0] == IDX_NEGZERO) ? IDX_ZERO : s[14:0];
    endfunction : oc_dec

    assign opc     = req.word[23:18];
    assign fj      = req.word[17:15];
    assign fsel    = req.word[17];
    assign fb      = req.word[16:15];
    assign fm      = req.word[14:0];
    assign sub     = req.word[17:12];
    assign subx    = req.word[11:9];
    assign p_inc   = oc_inc(req.p);
    assign cmp_rhs = (opc == OPC_COMPARE && fsel) ? req.aux : 24'h000000;

    always_comb
    begin
        unique case (fb)
            2'd1:    idx_cur = req.idx1;
            2'd2:    idx_cur = req.idx2;
            2'd3:    idx_cur = req.idx3;
            default: idx_cur = IDX_ZERO;
        endcase
    end

    jct_compare #(
        .W   (WORD_W)
    ) u_compare (
        .lhs (req.acc),
        .rhs (cmp_rhs),
        .sel (jct_cmp_t'(fb)),
        .hit (cmp_hit)
    );

    always_comb
    begin
        resp_next      = '0;
        resp_next.next_p = p_inc;
        flags_next     = flags_reg;
        origin_next    = origin_reg;
        hold_save_next = hold_save_reg;
        hold_exit_next = hold_exit_reg;
        pit_we         = 1'b0;
        pit_addr       = 7'(req.word[6:0]);
        pit_wdata      = req.acc[11:0];
        is_jump        = 1'b0;
        if (int_recognised)
            hold_save_next = 1'b1;
        if (req.valid)
        begin
            resp_next.done = 1'b1;
            if (req.word[PIT_MOD_BIT])
                pit_addr = 7'(req.word[6:0] + req.idx2[6:0]);
            unique case (opc)
                OPC_KEY:
                begin
                    is_jump = 1'b1;
                    if (fj == KEY_RETURN)
                    begin
                        resp_next.branch      = 1'b1;
                        resp_next.mem_we      = 1'b1;
                        resp_next.mem_addr    = fm;
                        resp_next.mem_data    = p_inc;
                        resp_next.mem_monitor = flags_reg[FLAG_BOUND];
                        resp_next.next_p      = oc_inc(fm);
                    end
                    else if (fj != 3'd0 && jump_keys[fj - 3'd1])
                    begin
                        resp_next.branch = 1'b1;
                        resp_next.next_p = fm;
                    end
                end
                OPC_UNCOND:
                begin
                    is_jump          = 1'b1;
                    resp_next.branch = 1'b1;
                    resp_next.next_p = req.eff_addr;
                end
                OPC_INDEX:
                begin
                    is_jump = 1'b1;
                    if (fb != 2'd0 && idx_cur != IDX_ZERO)
                    begin
                        resp_next.branch  = 1'b1;
                        resp_next.next_p  = fm;
                        resp_next.idx_we  = 1'b1;
                        resp_next.idx_sel = fb;
                        resp_next.idx     = fsel ? oc_dec(idx_cur)
                                                 : oc_inc(idx_cur);
                    end
                end
                OPC_COMPARE:
                begin
                    is_jump = 1'b1;
                    if (cmp_hit)
                    begin
                        resp_next.branch = 1'b1;
                        resp_next.next_p = fm;
                    end
                end
                OPC_DECIMAL:
                begin
                    is_jump = 1'b1;
                    if (!decimal_present || !decimal_switch_on)
                        resp_next.trap = 1'b1;
                    else if ((fj == 3'd0 && decimal_unit_result_flags == 2'd0)
                          || (fj == 3'd1 && decimal_unit_result_flags == 2'd1)
                          || (fj == 3'd2 && decimal_unit_result_flags == 2'd2))
                    begin
                        resp_next.branch = 1'b1;
                        resp_next.next_p = fm;
                    end
                end
                OPC_SPECIAL:
                begin
                    unique case (sub)
                        SUB_CHAN_RD:
                        begin
                            resp_next.acc_we = 1'b1;
                            resp_next.acc    = {21'h000000, channel_index_value};
                        end
                        SUB_PIT_WR:
                            pit_we = multiprog_present;
                        SUB_PIT_RD:
                        begin
                            resp_next.acc_we = multiprog_present;
                            resp_next.acc    = {12'h000, page_index_table[pit_addr]};
                        end
                        SUB_FLAGS:
                        begin
                            resp_next.acc_we = 1'b1;
                            if (subx == FLAGS_REST_X)
                            begin
                                resp_next.acc  = req.acc;
                                flags_next     = req.acc[5:0];
                                hold_exit_next = 1'b1;
                            end
                            else
                            begin
                                resp_next.acc  = {18'h00000, flags_reg};
                                flags_next     = FLAGS_RESET;
                                hold_save_next = int_recognised;
                            end
                        end
                        SUB_ORIGIN:
                        begin
                            resp_next.acc_we = 1'b1;
                            resp_next.acc    = {9'h000, origin_reg};
                        end
                        default: resp_next.acc = req.acc;
                    endcase
                end
                default: resp_next.acc = req.acc;
            endcase
            if (is_jump && resp_next.branch)
                hold_exit_next = 1'b0;
            if (is_jump && flags_reg[FLAG_PSTATE])
                origin_next = req.p;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            resp_reg      <= '0;
            flags_reg     <= FLAGS_RESET;
            origin_reg    <= IDX_ZERO;
            hold_save_reg <= 1'b0;
            hold_exit_reg <= 1'b0;
            int_hold_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            resp_reg      <= resp_next;
            flags_reg     <= flags_next;
            origin_reg    <= origin_next;
            hold_save_reg <= hold_save_next;
            hold_exit_reg <= hold_exit_next;
            int_hold_reg  <= hold_save_next || hold_exit_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (clk_en && pit_we)
            page_index_table[pit_addr] <= pit_wdata;
    end

    assign resp               = resp_reg;
    assign condition_flags    = flags_reg;
    assign last_branch_origin = origin_reg;
    assign int_hold           = int_hold_reg;

endmodule : jct_unit
`default_nettype wire

// file: test/jct_unit_assertions.sv
// Checker for the jump and condition transfer unit
`timescale 1ns/10ps
`default_nettype none
module jct_unit_chk
    import jct_pkg::*;
#(
    parameter int PIT_DEPTH = 128
)
(
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic               clk_en,
    // Watched ports
    input wire jct_pkg::jct_req_t  req,
    input wire logic [2:0]         channel_index_value,
    input wire logic               multiprog_present,
    input wire logic               decimal_present,
    input wire logic               decimal_switch_on,
    input wire logic               int_recognised,
    input wire jct_pkg::jct_resp_t resp,
    input wire logic [5:0]         condition_flags,
    input wire logic               int_hold
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic       v   = req.valid && clk_en;
    wire logic [5:0] opc = req.word[23:18];
    wire logic [5:0] sub = req.word[17:12];
    wire logic       sp  = v && opc == OPC_SPECIAL;
    wire logic       fs  = sp && sub == SUB_FLAGS && req.word[11:9] == FLAGS_SAVE_X;
    wire logic       fr  = sp && sub == SUB_FLAGS && req.word[11:9] == FLAGS_REST_X;
    wire logic       rt  = v && opc == OPC_KEY && req.word[17:15] == KEY_RETURN;
    AST_CHAN_READ: assert property (
        sp && sub == SUB_CHAN_RD |=> resp.acc_we && resp.acc[2:0] == $past(channel_index_value))
        else $error("channel read wrong");
    AST_FLAGS_SAVE: assert property (
        fs |=> resp.acc[5:0] == $past(condition_flags) && condition_flags == FLAGS_RESET)
        else $error("flags save wrong");
    AST_FLAGS_REST: assert property (
        fr |=> condition_flags == $past(req.acc[5:0])) else $error("flags restore wrong");
    AST_HOLD_RECOG: assert property (
        clk_en && int_recognised && !fs |=> int_hold) else $error("hold missing after interrupt");
    AST_HOLD_REST: assert property (
        fr |=> int_hold) else $error("hold missing after restore");
    AST_PIT_NOOP: assert property (
        sp && (sub == SUB_PIT_WR || sub == SUB_PIT_RD) && !multiprog_present
        |=> !resp.acc_we && resp.next_p == $past(req.p) + 15'h1) else $error("page op not idle");
    AST_DEC_TRAP: assert property (
        v && opc == OPC_DECIMAL && !(decimal_present && decimal_switch_on) |=> resp.trap)
        else $error("decimal branch not trapped");
    AST_UNCOND: assert property (
        v && opc == OPC_UNCOND |=> resp.branch && resp.next_p == $past(req.eff_addr))
        else $error("unconditional branch wrong");
    AST_RET_STORE: assert property (
        rt |=> resp.mem_we && resp.mem_addr == $past(req.word[14:0])
        && resp.mem_data == $past(req.p) + 15'h1) else $error("return store wrong");
    AST_RET_MON: assert property (
        rt |=> resp.mem_monitor == $past(condition_flags[FLAG_BOUND]))
        else $error("return store state wrong");
    COV_RET: cover property (rt);
    COV_TRAP: cover property (v && opc == OPC_DECIMAL ##1 resp.trap);
    COV_INDEX: cover property (v && opc == OPC_INDEX ##1 resp.idx_we);
endmodule : jct_unit_chk

bind jct_unit jct_unit_chk #(.PIT_DEPTH(PIT_DEPTH)) jct_unit_chk_i (.clk_sys(clk_sys),
    .rst(rst), .clk_en(clk_en), .req(req), .channel_index_value(channel_index_value),
    .multiprog_present(multiprog_present), .decimal_present(decimal_present),
    .decimal_switch_on(decimal_switch_on), .int_recognised(int_recognised), .resp(resp),
    .condition_flags(condition_flags), .int_hold(int_hold));
`default_nettype wire

// file: test/test_jct_unit.sv
// Self-checking testbench for the jump and condition transfer unit
`timescale 1ns/10ps
`default_nettype none
module test_jct_unit;
    import jct_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    jct_req_t    req = '0;
    jct_req_t    q = '0;
    logic [2:0]  chan = 3'h0;
    logic [5:0]  keys = 6'h00;
    logic        mp = 1'b1;
    logic        dp = 1'b1;
    logic        dsw = 1'b1;
    logic [1:0]  dflag = 2'h0;
    logic        irq = 1'b0;
    logic        ce = 1'b1;
    jct_resp_t   resp;
    logic [5:0]  flags;
    logic [14:0] origin;
    logic        hold;
    logic [15:0] st = 16'h0054;
    int          errors = 0;
    int          total_checks = 0;
    logic [23:0] r;
    logic [14:0] idx;
    logic [1:0]  b;
    logic        dn;
    logic        e;
    logic [14:0] cv [4] = '{15'h0000, 15'h7fff, 15'h7ffe, 15'h0001};
    logic [23:0] cz [4] = '{24'h000000, 24'hffffff, 24'h000001, 24'hfffffe};
    always #5 clk_sys = ~clk_sys;
    jct_unit jct_unit_i (.clk_sys(clk_sys), .rst(rst), .clk_en(ce), .req(req),
        .channel_index_value(chan), .jump_keys(keys), .multiprog_present(mp),
        .decimal_present(dp), .decimal_switch_on(dsw), .decimal_unit_result_flags(dflag),
        .int_recognised(irq), .resp(resp), .condition_flags(flags),
        .last_branch_origin(origin), .int_hold(hold));
    function automatic logic [23:0] rnd();
        st = {st[14:0], st[15] ^ st[13] ^ st[12] ^ st[10]};
        return {st[7:0], st};
    endfunction : rnd
    function automatic int key(logic [23:0] x, bit ord);
        int v;
        logic [23:0] nx;
        nx = ~x;
        v = x[23] ? -int'(nx) : int'(x);
        return ord ? 2 * v - int'(x == 24'hffffff) : v;
    endfunction : key
    function automatic logic hit(logic [23:0] a, logic [23:0] c, logic [1:0] j);
        case (j)
            2'h0: return key(a, 0) == key(c, 0);
            2'h1: return key(a, 0) != key(c, 0);
            2'h2: return key(a, 1) >= key(c, 1);
            default: return key(a, 1) < key(c, 1);
        endcase
    endfunction : hit
    function automatic logic [14:0] step(logic [14:0] x, logic down);
        logic [15:0] s;
        s = {1'b0, x} + 16'h0001;
        if (down)
            return x - 15'h0001;
        s = {15'h0000, s[15]} + s[14:0];
        return (s[14:0] == IDX_NEGZERO) ? IDX_ZERO : s[14:0];
    endfunction : step
    task automatic chk_val(logic [23:0] got, logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(logic got, logic exp);
        chk_val({23'h0, got}, {23'h0, exp});
    endtask : chk_bit
    task automatic go(logic [23:0] w, logic [14:0] p);
        q.valid = 1'b1;
        q.word = w;
        q.p = p;
        @(posedge clk_sys);
        req <= q;
        @(posedge clk_sys);
        req.valid <= 1'b0;
        @(negedge clk_sys);
    endtask : go
    task automatic flow(logic br, logic [14:0] tgt, logic [14:0] p);
        chk_bit(resp.done, 1'b1);
        chk_bit(resp.branch, br);
        chk_val(resp.next_p, br ? tgt : p + 15'h1);
    endtask : flow
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            @(posedge clk_sys);
            chan <= r[2:0];
            go({OPC_SPECIAL, SUB_CHAN_RD, 12'h000}, {1'b0, r[16:3]});
            chk_val(resp.acc[2:0], r[2:0]);
        end
        $display("end of channel read");
        r = rnd();
        q.acc = r;
        q.idx2 = 15'h0002;
        go({OPC_SPECIAL, SUB_PIT_WR, 12'h005}, 15'h0100);
        q.acc = ~r;
        go({OPC_SPECIAL, SUB_PIT_RD, 12'h803}, 15'h0101);
        chk_val(resp.acc[11:0], r[11:0]);
        @(posedge clk_sys);
        mp <= 1'b0;
        go({OPC_SPECIAL, SUB_PIT_WR, 12'h005}, 15'h0102);
        go({OPC_SPECIAL, SUB_PIT_RD, 12'h005}, 15'h0103);
        chk_bit(resp.acc_we, 1'b0);
        flow(1'b0, 15'h0, 15'h0103);
        @(posedge clk_sys);
        mp <= 1'b1;
        go({OPC_SPECIAL, SUB_PIT_RD, 12'h005}, 15'h0104);
        chk_val(resp.acc[11:0], r[11:0]);
        $display("end of page table");
        @(posedge clk_sys);
        irq <= 1'b1;
        @(posedge clk_sys);
        irq <= 1'b0;
        @(negedge clk_sys);
        chk_bit(hold, 1'b1);
        go({OPC_SPECIAL, SUB_FLAGS, FLAGS_SAVE_X, 9'h000}, 15'h0110);
        chk_bit(hold, 1'b0);
        q.acc = 24'h00002d;
        go({OPC_SPECIAL, SUB_FLAGS, FLAGS_REST_X, 9'h000}, 15'h0111);
        chk_val(flags, 6'h2d);
        chk_bit(hold, 1'b1);
        q.eff_addr = 15'h1234;
        go({OPC_UNCOND, 18'h00055}, 15'h0200);
        flow(1'b1, 15'h1234, 15'h0200);
        chk_bit(hold, 1'b0);
        go({OPC_SPECIAL, SUB_ORIGIN, 12'h000}, 15'h0201);
        chk_val(resp.acc[14:0], 15'h0200);
        for (int k = 0; k < 2; k++)
        begin
            go({OPC_KEY, KEY_RETURN, 15'h0300}, 15'h0210);
            chk_bit(resp.mem_we, 1'b1);
            chk_val(resp.mem_addr, 15'h0300);
            chk_val(resp.mem_data, 15'h0211);
            chk_val(resp.next_p, 15'h0301);
            chk_bit(resp.mem_monitor, k == 0);
            chk_val(origin, 15'h0210);
            go({OPC_SPECIAL, SUB_FLAGS, FLAGS_SAVE_X, 9'h000}, 15'h0220);
            chk_val(resp.acc[5:0], k == 0 ? 6'h2d : 6'h00);
            chk_val(flags, 6'h00);
            q.eff_addr = 15'h0200;
            go({OPC_UNCOND, 18'h00000}, 15'h0200);
        end
        q.acc = 24'h00003f;
        @(posedge clk_sys);
        ce <= 1'b0;
        go({OPC_SPECIAL, SUB_FLAGS, FLAGS_REST_X, 9'h000}, 15'h0230);
        chk_bit(resp.done, 1'b0);
        chk_val(flags, 6'h00);
        chk_bit(hold, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("end of flags and return");
        for (int j = 1; j < 7; j++)
        begin
            r = rnd();
            @(posedge clk_sys);
            keys <= r[5:0];
            go({OPC_KEY, 3'(j), r[22:8]}, 15'h0400);
            flow(r[j - 1], r[22:8], 15'h0400);
        end
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_sys);
            dflag <= 2'(i % 3);
            dp <= i != 9;
            dsw <= i != 10;
            go({OPC_DECIMAL, 3'((i / 3) % 3), 15'h0555}, 15'h0500);
            e = (i % 3) == ((i / 3) % 3);
            chk_bit(resp.trap, i > 8);
            if (i < 9)
                flow(e, 15'h0555, 15'h0500);
        end
        $display("end of key and decimal branches");
        for (int i = 0; i < 32; i++)
        begin
            r = rnd();
            idx = i < 8 ? cv[i % 4] : (r[14:0] | 15'h0001);
            dn = i < 8 ? (i / 4) : r[17];
            b = i < 8 ? 2'(1 + i % 3) : r[16:15];
            {q.idx3, q.idx2, q.idx1} = {3{~idx}};
            q.idx1 = b == 2'h1 ? idx : q.idx1;
            q.idx2 = b == 2'h2 ? idx : q.idx2;
            q.idx3 = b == 2'h3 ? idx : q.idx3;
            go({OPC_INDEX, dn, b, 15'h0600}, 15'h0610);
            e = b != 2'h0 && idx != 15'h0;
            flow(e, 15'h0600, 15'h0610);
            chk_bit(resp.idx_we, e);
            if (e)
                chk_val({resp.idx_sel, resp.idx}, {b, step(idx, dn)});
        end
        for (int i = 0; i < 96; i++)
        begin
            r = rnd();
            q.acc = i < 64 ? cz[i % 4] : rnd();
            q.aux = i < 64 ? cz[(i / 4) % 4] : rnd();
            b = i < 64 ? 2'((i / 16) % 4) : r[16:15];
            go({OPC_COMPARE, r[20], b, 15'h0700}, 15'h0710);
            flow(hit(q.acc, r[20] ? q.aux : 24'h0, b), 15'h0700, 15'h0710);
        end
        $display("end of index and compare branches");
        report_and_stop();
    end
endmodule : test_jct_unit
`default_nettype wire
